// [hsr_consts.svh]
// offsets, field positions and reset values of the sensor routing block
`ifndef HSR_CONSTS_SVH
`define HSR_CONSTS_SVH
`define HSR_OFF_CTRL        8'h00
`define HSR_OFF_PHSEL       8'h04
`define HSR_OFF_STATUS      8'h08
`define HSR_CTRL_POL        0
`define HSR_CTRL_SEL_LO     1
`define HSR_CTRL_SEL_HI     3
`define HSR_CTRL_SENSLESS   4
`define HSR_CTRL_SUPPLY_N   5
`define HSR_CTRL_TRIG       6
`define HSR_CTRL_RST        8'h20
`define HSR_PHSEL_RST       6'h00
`define HSR_RESP_OKAY       2'h0
`define HSR_RESP_SLVERR     2'h2
`endif

// [hsr_pkg.sv]
// types shared by the sensor routing block
package hsr_pkg;
	typedef enum logic [2:0] {
		HSR_ORD_ABC = 3'h0,
		HSR_ORD_ACB = 3'h1,
		HSR_ORD_BAC = 3'h2,
		HSR_ORD_BCA = 3'h3,
		HSR_ORD_AAB = 3'h4,
		HSR_ORD_ABA = 3'h5
	} hsrOrder_t;
	typedef struct packed {
		logic [7:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [7:0]  araddr;
		logic        arvalid;
		logic        rready;
	} hsrAxiReq_t;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} hsrAxiRsp_t;
endpackage : hsr_pkg

// [hsr_signal_routing.sv]
// rotor position sensor routing with axi4-lite control
// Operation
// - microcontroller line selects measured back-emf phase
// - sensorless drops speed pulse, commutation, lock
// - trigger applies phase selects, then self-clears
// - polarity bit inverts all three sensor inputs
// - selector code picks terminal per channel
// - routed signals feed microcontroller and commutation
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "hsr_consts.svh"
module hsr_signal_routing (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// register bus
	input  wire hsr_pkg::hsrAxiReq_t axiReq,
	output hsr_pkg::hsrAxiRsp_t     axiRsp,
	// sensor terminals and microcontroller side port
	input  wire logic [2:0]         positionIn,
	input  wire logic [2:0]         phaseMeasureSelect,
	// routed sensor signals
	output logic [2:0]              mcuSensorOut,
	output logic [2:0]              commutSensorOut,
	// phase measure and function gating
	output logic [2:0]              bemfPhaseSel,
	output logic                    speedPulseEn,
	output logic                    commutEn,
	output logic                    lockDetectEn,
	output logic                    sensorSupplySaveN,
	output logic [5:0]              phaseSelApplied
);
	import hsr_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	logic       rstMeta;
	logic       rstSyncN;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta  <= 1'b0;
			rstSyncN <= 1'b0;
		end else begin
			rstMeta  <= 1'b1;
			rstSyncN <= rstMeta;
		end
	end

	// pins: two flops before any logic; the first stage is read only by the second
	logic [5:0] pinMeta;
	logic [5:0] pinSync;
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			pinMeta <= 6'h00;
			pinSync <= 6'h00;
		end else begin
			pinMeta <= {phaseMeasureSelect, positionIn};
			pinSync <= pinMeta;
		end
	end
	logic [2:0] posSync;
	logic [2:0] measSync;
	assign posSync  = pinSync[2:0];
	assign measSync = pinSync[5:3];

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave: address and data taken in either order, one write and one read
	logic [7:0]  ctrlReg;
	logic [5:0]  phselReg;
	logic        awreadyReg, wreadyReg, awHeldReg, wHeldReg, bvalidReg;
	logic [1:0]  brespReg;
	logic [7:0]  awAddrReg;
	logic [31:0] wDataReg;
	logic [3:0]  wStrbReg;
	logic        arreadyReg, rvalidReg;
	logic [31:0] rdataReg;
	logic [1:0]  rrespReg;
	logic        doWrite;
	logic        wrCtrl;
	logic        wrPhsel;
	assign doWrite = awHeldReg && wHeldReg && !bvalidReg;
	assign wrCtrl  = doWrite && awAddrReg == `HSR_OFF_CTRL && wStrbReg[0];
	assign wrPhsel = doWrite && awAddrReg == `HSR_OFF_PHSEL && wStrbReg[0];

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			awreadyReg <= 1'b1;
			wreadyReg  <= 1'b1;
			awHeldReg  <= 1'b0;
			wHeldReg   <= 1'b0;
			awAddrReg  <= 8'h00;
			wDataReg   <= 32'h00000000;
			wStrbReg   <= 4'h0;
			bvalidReg  <= 1'b0;
			brespReg   <= `HSR_RESP_OKAY;
		end else begin
			if (axiReq.awvalid && awreadyReg) begin
				awreadyReg <= 1'b0;
				awHeldReg  <= 1'b1;
				awAddrReg  <= {axiReq.awaddr[7:2], 2'h0};
			end
			if (axiReq.wvalid && wreadyReg) begin
				wreadyReg <= 1'b0;
				wHeldReg  <= 1'b1;
				wDataReg  <= axiReq.wdata;
				wStrbReg  <= axiReq.wstrb;
			end
			if (doWrite) begin
				awHeldReg <= 1'b0;
				wHeldReg  <= 1'b0;
				bvalidReg <= 1'b1;
				brespReg  <= (awAddrReg == `HSR_OFF_CTRL || awAddrReg == `HSR_OFF_PHSEL ||
					awAddrReg == `HSR_OFF_STATUS) ? `HSR_RESP_OKAY : `HSR_RESP_SLVERR;
			end
			if (bvalidReg && axiReq.bready) begin
				bvalidReg  <= 1'b0;
				awreadyReg <= 1'b1;
				wreadyReg  <= 1'b1;
			end
		end
	end

	// control register; the trigger bit self-clears one cycle after it is set
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			ctrlReg <= `HSR_CTRL_RST;
		end else if (wrCtrl) begin
			ctrlReg <= wDataReg[7:0];   // a new trigger write wins over the self-clear
		end else begin
			ctrlReg[`HSR_CTRL_TRIG] <= 1'b0;
		end
	end

	// per-phase selects only reach the ports on a trigger
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			phselReg        <= `HSR_PHSEL_RST;
			phaseSelApplied <= `HSR_PHSEL_RST;
		end else begin
			if (wrPhsel) begin
				phselReg <= wDataReg[5:0];
			end
			if (ctrlReg[`HSR_CTRL_TRIG]) begin
				phaseSelApplied <= phselReg;
			end
		end
	end

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			arreadyReg <= 1'b1;
			rvalidReg  <= 1'b0;
			rdataReg   <= 32'h00000000;
			rrespReg   <= `HSR_RESP_OKAY;
		end else if (axiReq.arvalid && arreadyReg) begin
			arreadyReg <= 1'b0;
			rvalidReg  <= 1'b1;
			rrespReg   <= `HSR_RESP_OKAY;
			case ({axiReq.araddr[7:2], 2'h0})
				`HSR_OFF_CTRL:   rdataReg <= {24'h000000, ctrlReg};
				`HSR_OFF_PHSEL:  rdataReg <= {26'h0000000, phselReg};
				`HSR_OFF_STATUS: rdataReg <= {23'h000000, bemfPhaseSel, mcuSensorOut, posSync};
				default: begin
					rdataReg <= 32'h00000000;
					rrespReg <= `HSR_RESP_SLVERR;
				end
			endcase
		end else if (rvalidReg && axiReq.rready) begin
			rvalidReg  <= 1'b0;
			arreadyReg <= 1'b1;
		end
	end

	assign axiRsp = '{awready: awreadyReg, wready: wreadyReg, bvalid: bvalidReg, bresp: brespReg,
		arready: arreadyReg, rvalid: rvalidReg, rdata: rdataReg, rresp: rrespReg};

	////////////////////////////////////////////////////////////////////////////////
	// routing: invert each terminal first, then pick, so duplicated channels match
	logic [2:0] polIn;
	logic [2:0] routedNext;
	assign polIn = posSync ^ {3{ctrlReg[`HSR_CTRL_POL]}};
	always_comb begin
		case (hsrOrder_t'(ctrlReg[`HSR_CTRL_SEL_HI:`HSR_CTRL_SEL_LO]))
			HSR_ORD_ACB: routedNext = {polIn[1], polIn[2], polIn[0]};
			HSR_ORD_BAC: routedNext = {polIn[2], polIn[0], polIn[1]};
			HSR_ORD_BCA: routedNext = {polIn[0], polIn[2], polIn[1]};
			HSR_ORD_AAB: routedNext = {polIn[1], polIn[0], polIn[0]};
			HSR_ORD_ABA: routedNext = {polIn[0], polIn[1], polIn[0]};
			// prohibited codes fall back to straight order
			default:     routedNext = polIn;
		endcase
	end

	// one register stage so outputs come from flops; both consumers see the same value
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			mcuSensorOut    <= 3'h0;
			commutSensorOut <= 3'h0;
		end else begin
			mcuSensorOut    <= routedNext;
			commutSensorOut <= routedNext;
		end
	end

	// sensorless: side-port lines pick the measured phase, hall-only functions drop
	logic sensless;
	assign sensless = ctrlReg[`HSR_CTRL_SENSLESS];
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			bemfPhaseSel      <= 3'h0;
			speedPulseEn      <= 1'b0;
			commutEn          <= 1'b0;
			lockDetectEn      <= 1'b0;
			sensorSupplySaveN <= 1'b1;
		end else begin
			// relies on the microcontroller raising one line at a time
			bemfPhaseSel      <= sensless ? measSync : 3'h0;
			speedPulseEn      <= !sensless;
			commutEn          <= !sensless;
			lockDetectEn      <= !sensless;
			sensorSupplySaveN <= ctrlReg[`HSR_CTRL_SUPPLY_N]; // software clears it before mode change
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!rstSyncN);

	property p_trig_apply;
		ctrlReg[`HSR_CTRL_TRIG] && !wrPhsel |=> phaseSelApplied == $past(phselReg);
	endproperty
	a_trig_apply: assert property (p_trig_apply) else $error("trigger did not apply selects");
	property p_trig_clear;
		wrCtrl && wDataReg[`HSR_CTRL_TRIG] ##1 !wrCtrl |=> !ctrlReg[`HSR_CTRL_TRIG];
	endproperty
	a_trig_clear: assert property (p_trig_clear) else $error("trigger bit did not self-clear");
	property p_keep;
		!ctrlReg[`HSR_CTRL_TRIG] |=> $stable(phaseSelApplied);
	endproperty
	a_keep: assert property (p_keep) else $error("port selection changed without trigger");
	property p_polarity;
		$stable(posSync) && $stable(ctrlReg[3:1]) && $changed(ctrlReg[0]) |=> mcuSensorOut == ~$past(mcuSensorOut);
	endproperty
	a_polarity: assert property (p_polarity) else $error("polarity flip did not invert outputs");
	property p_straight;
		ctrlReg[3:0] == 4'h0 |=> mcuSensorOut == $past(posSync);
	endproperty
	a_straight: assert property (p_straight) else $error("straight order not passed through");
	property p_dup;
		ctrlReg[3:1] == 3'h4 |=> mcuSensorOut[0] == mcuSensorOut[1] && mcuSensorOut[1] == $past(polIn[0]);
	endproperty
	a_dup: assert property (p_dup) else $error("duplicated channels differ");
	property p_both;
		commutSensorOut == mcuSensorOut;
	endproperty
	a_both: assert property (p_both) else $error("routed paths disagree");
	property p_sensless;
		sensless ##1 sensless |=> !speedPulseEn && !commutEn && !lockDetectEn;
	endproperty
	a_sensless: assert property (p_sensless) else $error("hall functions active in sensorless");
	property p_bemf;
		sensless && $onehot(measSync) |=> bemfPhaseSel == $past(measSync);
	endproperty
	a_bemf: assert property (p_bemf) else $error("measured phase not followed");
	c_trigger: cover property (ctrlReg[`HSR_CTRL_TRIG] ##1 $changed(phaseSelApplied));
	c_swap: cover property (ctrlReg[3:1] == 3'h3 && mcuSensorOut != 3'h0);
	c_bemf: cover property (sensless && bemfPhaseSel == 3'h2);
endmodule : hsr_signal_routing

// [hsr_sensor_model.sv]
// sensor terminal and microcontroller side port model for the routing bench
`timescale 1ns/100ps
module hsr_sensor_model (
	// bench controls
	input  wire logic [2:0] hallStep,
	input  wire logic [1:0] measPhase,
	// device pins
	output logic      [2:0] positionIn,
	output logic      [2:0] phaseMeasureSelect
);
	always_comb begin
		// six-step pattern keeps only one terminal changing per step
		case (hallStep)
			3'h0:    positionIn = 3'h1;
			3'h1:    positionIn = 3'h3;
			3'h2:    positionIn = 3'h2;
			3'h3:    positionIn = 3'h6;
			3'h4:    positionIn = 3'h4;
			default: positionIn = 3'h5;
		endcase
	end
	// a phase index can light one line at most, so two lines never meet
	assign phaseMeasureSelect = (measPhase == 2'h0) ? 3'h0 : (3'h1 << (measPhase - 2'h1));
endmodule : hsr_sensor_model

// [hsr_signal_routing_tb_top.sv]
// self-checking bench for the sensor routing block
`timescale 1ns/100ps
`include "hsr_consts.svh"
module hsr_signal_routing_tb_top;
	import hsr_pkg::*;
	logic             clk;
	logic             rst_n;
	hsrAxiReq_t       axiReq;
	hsrAxiRsp_t       axiRsp;
	logic [2:0]       positionIn, phaseMeasureSelect, mcuSensorOut, commutSensorOut, bemfPhaseSel;
	logic             speedPulseEn, commutEn, lockDetectEn, sensorSupplySaveN;
	logic [5:0]       phaseSelApplied;
	logic [2:0]       hallStep;
	logic [1:0]       measPhase, r;
	logic [31:0]      d;
	int               errCount, checked;
	hsr_signal_routing hsr_signal_routing_i (.clk(clk), .rst_n(rst_n), .axiReq(axiReq), .axiRsp(axiRsp),
		.positionIn(positionIn), .phaseMeasureSelect(phaseMeasureSelect), .mcuSensorOut(mcuSensorOut),
		.commutSensorOut(commutSensorOut), .bemfPhaseSel(bemfPhaseSel), .speedPulseEn(speedPulseEn),
		.commutEn(commutEn), .lockDetectEn(lockDetectEn), .sensorSupplySaveN(sensorSupplySaveN),
		.phaseSelApplied(phaseSelApplied));
	hsr_sensor_model hsr_sensor_model_i (.hallStep(hallStep), .measPhase(measPhase), .positionIn(positionIn),
		.phaseMeasureSelect(phaseMeasureSelect));
	////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errCount++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task finish_test;
		if (errCount == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test
	// handshakes are judged at the falling edge, where design outputs are settled
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw, w, b;
		b = 1'b0;
		@(posedge clk);
		axiReq.awaddr <= a;
		axiReq.awvalid <= 1'b1;
		axiReq.wdata <= v;
		axiReq.wstrb <= 4'hf;
		axiReq.wvalid <= 1'b1;
		axiReq.bready <= 1'b1;
		for (int n = 0; n < 40 && !b; n++) begin
			@(negedge clk);
			aw = axiReq.awvalid && axiRsp.awready;
			w = axiReq.wvalid && axiRsp.wready;
			b = axiReq.bready && axiRsp.bvalid;
			rs = axiRsp.bresp;
			@(posedge clk);
			if (aw) axiReq.awvalid <= 1'b0;
			if (w) axiReq.wvalid <= 1'b0;
			if (b) axiReq.bready <= 1'b0;
		end
		if (!b) begin
			errCount++;
			finish_test();
		end
	endtask : axiWrite
	task automatic axiRead(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		logic ar, rd;
		rd = 1'b0;
		@(posedge clk);
		axiReq.araddr <= a;
		axiReq.arvalid <= 1'b1;
		axiReq.rready <= 1'b1;
		for (int n = 0; n < 40 && !rd; n++) begin
			@(negedge clk);
			ar = axiReq.arvalid && axiRsp.arready;
			rd = axiReq.rready && axiRsp.rvalid;
			v = axiRsp.rdata;
			rs = axiRsp.rresp;
			@(posedge clk);
			if (ar) axiReq.arvalid <= 1'b0;
			if (rd) axiReq.rready <= 1'b0;
		end
		if (!rd) begin
			errCount++;
			finish_test();
		end
	endtask : axiRead
	// terminal index feeding U, V, W for each order code; inversion comes first
	function automatic logic [2:0] expRoute(input logic [2:0] pin, input int code, input logic pol);
		int idx [6][3] = '{'{0, 1, 2}, '{0, 2, 1}, '{1, 0, 2}, '{1, 2, 0}, '{0, 0, 1}, '{0, 1, 0}};
		logic [2:0] inv;
		inv = pin ^ {3{pol}};
		for (int k = 0; k < 3; k++) expRoute[k] = inv[idx[code][k]];
	endfunction : expRoute
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		axiReq = '0;
		rst_n = 1'b0;
		hallStep = 3'h0;
		measPhase = 2'h0;
		errCount = 0;
		checked = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		axiRead(`HSR_OFF_CTRL, d, r);
		cmp(d, 32'(`HSR_CTRL_RST));
		axiRead(`HSR_OFF_PHSEL, d, r);
		cmp(d, 32'h0);
		cmp(32'({speedPulseEn, commutEn, lockDetectEn, sensorSupplySaveN}), 32'hf);
		axiRead(8'h0c, d, r);
		cmp(d, 32'h0);
		cmp(32'(r), 32'(`HSR_RESP_SLVERR));
		axiWrite(8'h0c, 32'h1, r);
		cmp(32'(r), 32'(`HSR_RESP_SLVERR));
		for (int pol = 0; pol < 2; pol++) begin
			for (int code = 0; code < 6; code++) begin
				axiWrite(`HSR_OFF_CTRL, 32'h20 | (code << 1) | pol, r);
				for (int s = 0; s < 6; s++) begin
					@(posedge clk);
					hallStep <= s[2:0];
					repeat (4) @(posedge clk);
					@(negedge clk);
					cmp(32'(mcuSensorOut), 32'(expRoute(positionIn, code, pol[0])));
					cmp(32'(commutSensorOut), 32'(expRoute(positionIn, code, pol[0])));
				end
			end
		end
		// polarity alone flips; the order stays on the last code
		axiWrite(`HSR_OFF_CTRL, 32'h2a, r);
		@(negedge clk);
		cmp(32'(mcuSensorOut), 32'(expRoute(positionIn, 5, 1'b0)));
		axiWrite(`HSR_OFF_PHSEL, 32'h2d, r);
		axiWrite(`HSR_OFF_CTRL, 32'h20, r);
		@(negedge clk);
		cmp(32'(phaseSelApplied), 32'h0);
		axiWrite(`HSR_OFF_CTRL, 32'h60, r);
		@(negedge clk);
		cmp(32'(phaseSelApplied), 32'h2d);
		axiRead(`HSR_OFF_CTRL, d, r);
		cmp(d, 32'h20);
		// a write without the trigger leaves the applied selects alone
		axiWrite(`HSR_OFF_PHSEL, 32'h12, r);
		axiWrite(`HSR_OFF_CTRL, 32'h20, r);
		@(negedge clk);
		cmp(32'(phaseSelApplied), 32'h2d);
		// supply save goes low before the driving method changes
		axiWrite(`HSR_OFF_CTRL, 32'h00, r);
		@(negedge clk);
		cmp(32'(sensorSupplySaveN), 32'h0);
		axiWrite(`HSR_OFF_CTRL, 32'h10, r);
		repeat (2) @(posedge clk);
		@(negedge clk);
		cmp(32'({speedPulseEn, commutEn, lockDetectEn}), 32'h0);
		for (int p = 1; p < 4; p++) begin
			@(posedge clk);
			measPhase <= p[1:0];
			repeat (4) @(posedge clk);
			@(negedge clk);
			cmp(32'(bemfPhaseSel), 32'h1 << (p - 1));
		end
		// status: measured phase W, straight order on terminal pattern c,a high
		axiRead(`HSR_OFF_STATUS, d, r);
		cmp(d, {23'h000000, 3'h4, 3'h5, 3'h5});
		@(posedge clk);
		measPhase <= 2'h0;
		axiWrite(`HSR_OFF_CTRL, 32'h20, r);
		repeat (4) @(posedge clk);
		@(negedge clk);
		cmp(32'({speedPulseEn, commutEn, lockDetectEn, bemfPhaseSel}), 32'h38);
		finish_test();
	end
endmodule : hsr_signal_routing_tb_top
